// File: logic/cft_pkg.sv
`default_nettype none
package cft_pkg;
  // System clock period in ns.
  localparam int unsigned CLK_PERIOD_NS  = 100;
  // Oscillator periods in one legacy machine cycle.
  localparam logic [3:0]  MCYC_CLKS      = 4'hc;
  // Clocks between fetch slots when paced.
  localparam logic [3:0]  FETCH_DIV      = 4'h3;
  // Fetch slots inside one legacy machine cycle.
  localparam logic [4:0]  SLOTS_PER_MCYC = 5'h4;
  // Address of the first instruction after reset.
  localparam logic [15:0] RESET_PC       = 16'h0000;
  // Machine-cycle count codes from the decoder.
  localparam logic [1:0]  MC_ONE         = 2'h0;
  localparam logic [1:0]  MC_TWO         = 2'h1;
  localparam logic [1:0]  MC_FOUR        = 2'h2;
endpackage : cft_pkg
`default_nettype wire

// File: logic/cft_seq.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE1 - Fuse cleared selects fast mode; fuse set selects legacy twelve-clock mode.
// RULE2 - Fast mode fetches one code byte every system clock.
// RULE3 - Next opcode is fetched while the current instruction still executes.
// RULE4 - Instructions are one to three bytes; fast timing equals byte count.
// RULE5 - Fast branches and calls add one cycle; complex ones add more.
// RULE6 - Fast mode from external code memory runs three times slower.
// RULE7 - Legacy mode fetches a byte every third clock.
// RULE8 - Legacy mode runs six two-clock states, twelve clocks per machine cycle.
// RULE9 - Legacy instructions take one, two or four machine cycles.
// RULE10 - Legacy timing ignores whether code is internal or external.
// RULE11 - Taken branch discards the prefetched byte and refetches at the target.
module cft_seq (
  input  wire logic        clk_in,       // System clock.
  input  wire logic        resetn_in,    // Asynchronous reset, active low.
  input  wire logic        en_in,        // Clock enable, freezes all state when low.
  input  wire logic        compat_fuse_in, // Compatibility fuse, high selects legacy mode.
  input  wire logic        code_ext_in,  // Current fetch targets external code memory.
  input  wire logic [7:0]  code_rdata_in, // Code byte at code_addr_out, same cycle.
  input  wire logic [1:0]  dec_len_in,   // Byte count 1..3 of the opcode on code_rdata_in.
  input  wire logic [1:0]  dec_extra_in, // Extra fast-mode cycles of that opcode.
  input  wire logic        dec_branch_in, // That opcode is a branch or call.
  input  wire logic [1:0]  dec_mcyc_in,  // Legacy machine-cycle code of that opcode.
  input  wire logic        taken_in,     // Branch taken, valid one slot before the end.
  input  wire logic [15:0] target_in,    // Branch target, valid with taken_in.
  output logic      [15:0] code_addr_out, // Code fetch address.
  output logic             code_rd_out,  // Code fetch strobe for this cycle.
  output logic      [7:0]  opcode_out,   // Opcode of the executing instruction.
  output logic             start_out,    // Pulse one cycle after an instruction begins.
  output logic             fast_mode_out, // Captured mode, high in fast mode.
  output logic      [2:0]  mstate_out    // Legacy machine-cycle state 0..5.
);
  import cft_pkg::*;

  // Sequencer registers and their next values.
  logic        cap_q;
  logic        fast_q;
  logic [3:0]  ph_q, ph_d;
  logic        tick_q, tick_d;
  logic        rd_q, rd_d;
  logic [15:0] pc_q, pc_d;
  logic [1:0]  need_q, need_d;
  logic        active_q, active_d;
  logic [4:0]  cnt_q, cnt_d;
  logic        br_q, br_d;
  logic [1:0]  len_q, len_d;
  logic [1:0]  xtra_q, xtra_d;
  logic        pf_valid_q, pf_valid_d;
  logic [7:0]  pf_op_q, pf_op_d;
  logic [4:0]  pf_tot_q, pf_tot_d;
  logic [1:0]  pf_len_q, pf_len_d;
  logic [1:0]  pf_xtra_q, pf_xtra_d;
  logic        pf_br_q, pf_br_d;
  logic [7:0]  op_q, op_d;
  logic        start_q;
  logic        cap_op, done, flush, start, run;
  logic [4:0]  dec_tot;

  // Legacy machine cycles expressed in fetch slots.
  function automatic logic [4:0] mcyc_slots(input logic [1:0] code);
    unique case (code)
      MC_ONE:  mcyc_slots = SLOTS_PER_MCYC;
      MC_TWO:  mcyc_slots = 5'(SLOTS_PER_MCYC * 2);
      default: mcyc_slots = 5'(SLOTS_PER_MCYC * 4);
    endcase
  endfunction : mcyc_slots

  // Slot count of the opcode now on the bus, per mode.
  always_comb begin
    if (fast_q) begin
      dec_tot = 5'(dec_len_in) + 5'(dec_extra_in) + 5'(dec_branch_in); // RULE4 RULE5
    end else begin
      dec_tot = mcyc_slots(dec_mcyc_in); // RULE9
    end
  end

  // Mode fuse is caught once, at the first enabled edge after reset release.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cap_q  <= 1'b0;
      fast_q <= 1'b0;
    end else if (en_in && !cap_q) begin
      cap_q  <= 1'b1;
      fast_q <= !compat_fuse_in; // RULE1
    end
  end

  // The whole sequencer waits for the captured mode; en_in low also freezes it.
  assign run = en_in && cap_q;

  // Next state of the fetch and execute sequencer.
  always_comb begin
    ph_d       = (ph_q == MCYC_CLKS - 4'h1) ? 4'h0 : ph_q + 4'h1; // RULE8
    // Paced slots every third clock; fast internal code uses every clock.
    tick_d     = (fast_q && !code_ext_in) || (4'(ph_d % FETCH_DIV) == 4'h0); // RULE2 RULE6 RULE7 RULE10
    cap_op     = rd_q && (need_q == 2'h0);
    done       = active_q && tick_q && (cnt_q == 5'h01);
    // A taken branch redirects one slot before its end, so the target opcode is
    // fetched in the final slot and the branch keeps its full decoded slot count.
    // The byte prefetched in the redirect slot is dropped.
    flush      = active_q && tick_q && (cnt_q == 5'h02) && br_q && taken_in;
    start      = tick_q && (!active_q || done) && (pf_valid_q || cap_op) && !flush; // RULE3
    pc_d       = rd_q ? pc_q + 16'h0001 : pc_q;
    need_d     = (rd_q && need_q != 2'h0) ? need_q - 2'h1 : need_q;
    active_d   = active_q && !done;
    cnt_d      = (active_q && tick_q) ? cnt_q - 5'h01 : cnt_q;
    br_d       = br_q;
    len_d      = len_q;
    xtra_d     = xtra_q;
    op_d       = op_q;
    pf_valid_d = pf_valid_q || cap_op;
    pf_op_d    = cap_op ? code_rdata_in : pf_op_q;
    pf_tot_d   = cap_op ? dec_tot : pf_tot_q;
    pf_len_d   = cap_op ? dec_len_in : pf_len_q;
    pf_xtra_d  = cap_op ? dec_extra_in : pf_xtra_q;
    pf_br_d    = cap_op ? dec_branch_in : pf_br_q;
    if (start) begin
      active_d   = 1'b1;
      pf_valid_d = 1'b0;
      cnt_d      = pf_tot_d;
      need_d     = pf_len_d - 2'h1;
      len_d      = pf_len_d;
      xtra_d     = pf_xtra_d;
      br_d       = pf_br_d;
      op_d       = pf_op_d;
    end
    if (flush) begin
      pf_valid_d = 1'b0; // RULE11
      pc_d       = target_in; // RULE11
      need_d     = 2'h0;
    end
    rd_d = tick_d && ((need_d != 2'h0) || !pf_valid_d); // RULE2 RULE3
  end

  // Sequencer state, frozen until the mode is known and while disabled.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ph_q       <= 4'h0;
      // Phase zero is a slot, so the slot flag starts high with the phase.
      tick_q     <= 1'b1;
      rd_q       <= 1'b0;
      pc_q       <= RESET_PC;
      need_q     <= 2'h0;
      active_q   <= 1'b0;
      cnt_q      <= 5'h00;
      br_q       <= 1'b0;
      len_q      <= 2'h0;
      xtra_q     <= 2'h0;
      op_q       <= 8'h00;
      pf_valid_q <= 1'b0;
      pf_op_q    <= 8'h00;
      pf_tot_q   <= 5'h00;
      pf_len_q   <= 2'h0;
      pf_xtra_q  <= 2'h0;
      pf_br_q    <= 1'b0;
      start_q    <= 1'b0;
    end else if (run) begin
      ph_q       <= ph_d;
      tick_q     <= tick_d;
      rd_q       <= rd_d;
      pc_q       <= pc_d;
      need_q     <= need_d;
      active_q   <= active_d;
      cnt_q      <= cnt_d;
      br_q       <= br_d;
      len_q      <= len_d;
      xtra_q     <= xtra_d;
      op_q       <= op_d;
      pf_valid_q <= pf_valid_d;
      pf_op_q    <= pf_op_d;
      pf_tot_q   <= pf_tot_d;
      pf_len_q   <= pf_len_d;
      pf_xtra_q  <= pf_xtra_d;
      pf_br_q    <= pf_br_d;
      start_q    <= start;
    end
  end

  // Outputs are the registers themselves; the state index halves the phase.
  assign code_addr_out = pc_q;
  assign code_rd_out   = rd_q;
  assign opcode_out    = op_q;
  assign start_out     = start_q;
  assign fast_mode_out = fast_q;
  assign mstate_out    = ph_q[3:1]; // RULE8

  // Checks below watch the sequencer registers; all are quiet while reset is low.
  // Each one names the rule it guards at the end of its label line.
  // The fuse value at the capture edge decides the mode.
  chk_fuse_mode_pick: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE1
    $rose(cap_q) |-> (fast_q == !$past(compat_fuse_in)))
    else $error("mode does not follow fuse");

  // Internal fast code: operand fetches run on consecutive clocks.
  chk_fast_byte_rate: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE2
    (run && fast_q && !code_ext_in && rd_q && need_q == 2'h2 && !flush) |=> rd_q)
    else $error("fast mode skipped a fetch clock");

  // A last operand fetch is followed by the next opcode fetch while executing.
  chk_pipe_overlap: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE3
    (run && rd_q && need_q == 2'h1 && fast_q && !code_ext_in && !flush) |=> rd_q && need_q == 2'h0)
    else $error("next opcode not prefetched");

  // Plain fast instructions last exactly their byte count.
  chk_fast_len_time: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE4
    (start_q && fast_q && !br_q && xtra_q == 2'h0) |-> (cnt_q == 5'(len_q) && len_q != 2'h0))
    else $error("fast instruction time differs from length");

  // Branches take one slot beyond length plus extras.
  chk_branch_extra: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE5
    (start_q && fast_q && br_q) |-> (cnt_q == 5'(len_q) + 5'(xtra_q) + 5'h01))
    else $error("branch cycle count wrong");

  // External fast code is paced to every third clock.
  chk_ext_pacing: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE6
    (fast_q && $past(run) && $past(code_ext_in) && rd_q) |-> (4'(ph_q % FETCH_DIV) == 4'h0))
    else $error("external fetch not paced by three");

  // Legacy fetch slots fall only on every third phase, regardless of memory.
  chk_compat_slots: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE7 RULE10
    (cap_q && !fast_q) |-> (tick_q == (4'(ph_q % FETCH_DIV) == 4'h0)))
    else $error("legacy fetch slot misplaced");

  // The machine-cycle phase wraps after twelve clocks.
  chk_mcyc_wrap: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE8
    (run && ph_q == 4'hb) |=> (ph_q == 4'h0 && mstate_out == 3'h0))
    else $error("machine cycle not twelve clocks");

  // Legacy instructions last one, two or four machine cycles.
  chk_compat_mcyc: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE9
    (start_q && !fast_q) |-> (cnt_q == 5'h04 || cnt_q == 5'h08 || cnt_q == 5'h10))
    else $error("legacy cycle count illegal");

  // A taken branch refetches at the target with no prefetch kept.
  chk_flush_target: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE11
    (run && flush) |=> (pc_q == $past(target_in) && !pf_valid_q && active_q && cnt_q == 5'h01))
    else $error("taken branch did not redirect");

  // A fetch strobe only ever stands in a fetch slot.
  chk_fetch_on_slot: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE2 RULE7
    (cap_q && rd_q) |-> tick_q)
    else $error("fetch outside a slot");

  // The phase counter never leaves the twelve-clock range.
  chk_phase_range: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE8
    cap_q |-> (ph_q < MCYC_CLKS))
    else $error("phase out of range");

  // Only six machine states exist.
  chk_state_range: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE8
    (mstate_out <= 3'h5))
    else $error("machine state out of range");

  // Once captured the mode cannot change until the next reset.
  chk_mode_fixed: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE1
    (cap_q && $past(cap_q)) |-> $stable(fast_q))
    else $error("mode changed after capture");

  // Nothing is fetched or started before the mode is known.
  chk_idle_before_mode: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE1
    !cap_q |-> (pc_q == RESET_PC && !rd_q && !start_q))
    else $error("activity before mode capture");

  // A held prefetch with no operand due stops further fetches.
  chk_hold_prefetch: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE3
    (run && pf_valid_q && need_q == 2'h0 && !start && !flush) |=> !rd_q)
    else $error("fetch while prefetch held");

  // An executing instruction always has slots left.
  chk_count_live: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE4
    active_q |-> (cnt_q != 5'h00))
    else $error("active with empty count");

  // A start pulse always belongs to an executing instruction.
  chk_start_active: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE3
    start_q |-> active_q)
    else $error("start without execution");

  // With the clock enable low the address and phase stand still.
  chk_freeze_hold: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE8
    (cap_q && !en_in) |=> ($stable(pc_q) && $stable(ph_q)))
    else $error("state moved while disabled");

  // Every fetch advances the address by one byte unless redirected.
  chk_addr_step: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE2
    (run && rd_q && !flush) |=> (pc_q == $past(pc_q) + 16'h0001))
    else $error("fetch address did not step");

  // An instruction that ends with nothing ready leaves the core idle.
  chk_done_retire: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE4
    (run && done && !start) |=> !active_q)
    else $error("finished instruction still active");

  // Each slot of an executing instruction takes one from its count.
  chk_count_step: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE4
    (run && active_q && tick_q && !done) |=> (cnt_q == $past(cnt_q) - 5'h01))
    else $error("slot count did not step");

endmodule : cft_seq
`default_nettype wire

// File: test/cft_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Program memory with a zero-wait read port and a small opcode decoder.
// Decoder fields: bits 1:0 length, 3:2 extra cycles, 4 branch, 6:5 machine cycles.
module cft_mem_model (
  input  wire logic [15:0] addr_in,    // Fetch address.
  input  wire logic        rd_in,      // Fetch strobe.
  output logic      [7:0]  rdata_out,  // Code byte.
  output logic             ext_out,    // Upper half of the map is external.
  output logic      [1:0]  len_out,    // Byte count.
  output logic      [1:0]  extra_out,  // Extra fast cycles.
  output logic             branch_out, // Branch or call.
  output logic      [1:0]  mcyc_out    // Machine-cycle code.
);
  logic [7:0] rom [0:65535];
  logic [7:0] b;
  // Outside a fetch the bus shows the inverted byte, so stale data is never trusted.
  always_comb begin
    b          = rom[addr_in];
    rdata_out  = rd_in ? b : ~b;
    ext_out    = addr_in[15];
    len_out    = b[1:0];
    extra_out  = b[3:2];
    branch_out = b[4];
    mcyc_out   = b[6:5];
  end
endmodule : cft_mem_model
`default_nettype wire

// File: test/cft_seq_test.sv
`timescale 1ns/1ps
`default_nettype none
module cft_seq_test;
  import cft_pkg::*;
  logic        clk_in, resetn_in, en_in, compat_fuse_in, code_ext_in, dec_branch_in, taken_in;
  logic [7:0]  code_rdata_in, opcode_out;
  logic [1:0]  dec_len_in, dec_extra_in, dec_mcyc_in;
  logic [15:0] target_in, code_addr_out;
  logic        code_rd_out, start_out, fast_mode_out;
  logic [2:0]  mstate_out;
  int          err_count, total_checks;
  // Gap tables; a zero entry is a fast-mode gap that crosses the move to external code.
  localparam int FGAP[10] = '{1, 2, 3, 3, 0, 6, 9, 3, 6, 9};
  localparam int LGAP[10] = '{12, 24, 48, 48, 12, 24, 48, 12, 24, 48};
  localparam logic [7:0] OPS[11] = '{8'h01, 8'h22, 8'h43, 8'h52, 8'h01, 8'h22, 8'h52,
                                     8'h01, 8'h22, 8'h52, 8'h01};

  cft_seq u_dut (.clk_in, .resetn_in, .en_in, .compat_fuse_in, .code_ext_in, .code_rdata_in,
    .dec_len_in, .dec_extra_in, .dec_branch_in, .dec_mcyc_in, .taken_in, .target_in,
    .code_addr_out, .code_rd_out, .opcode_out, .start_out, .fast_mode_out, .mstate_out);
  cft_mem_model u_mem (.addr_in(code_addr_out), .rd_in(code_rd_out), .rdata_out(code_rdata_in),
    .ext_out(code_ext_in), .len_out(dec_len_in), .extra_out(dec_extra_in),
    .branch_out(dec_branch_in), .mcyc_out(dec_mcyc_in));

  // Free-running system clock.
  initial clk_in = 1'b0;
  always #50 clk_in = ~clk_in;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  // Resets in the given mode and times eleven instruction starts, watching fetches and states.
  task automatic run_prog(input logic fuse, output int gap[10], output logic [7:0] op[11]);
    int cyc, last, n, nrd, lrd, hold, nchg;
    logic [2:0] mprev;
    cyc = 0; last = 0; n = 0; nrd = 0; lrd = 0; hold = 0; nchg = 0;
    compat_fuse_in = fuse;
    resetn_in = 1'b0;
    repeat (2) @(negedge clk_in);
    resetn_in = 1'b1;
    mprev = mstate_out;
    while (n < 11 && cyc < 2000) begin
      @(negedge clk_in);
      cyc++;
      if (start_out === 1'b1) begin
        op[n] = opcode_out;
        if (opcode_out == 8'h01) check("restart address", code_addr_out, (n == 0) ? 16'h0001 : 16'h8001);
        if (n > 0) gap[n-1] = cyc - last;
        last = cyc;
        n++;
      end
      if (code_rd_out === 1'b1) begin
        nrd++;
        if (fuse && nrd > 1) check("fetch spacing", (cyc - lrd) % 3, 0);
        if (!fuse && nrd > 1 && nrd <= 6) check("fetch each clock", cyc - lrd, 1);
        lrd = cyc;
      end
      if (fuse && mstate_out !== mprev) begin
        if (nchg > 0) check("state hold", hold, 2);
        if (nchg > 0) check("state step", mstate_out, (mprev == 3'h5) ? 0 : mprev + 1);
        nchg++;
        hold = 1;
      end else hold++;
      mprev = mstate_out;
    end
    check("start count", n, 11);
  endtask : run_prog

  // Fast mode: byte-count timing, branch penalty, external slowdown and refetch at target.
  task automatic test_fast();
    int g[10];
    logic [7:0] o[11];
    run_prog(1'b0, g, o);
    check("fast mode flag", fast_mode_out, 1);
    for (int i = 0; i < 10; i++) if (FGAP[i] != 0) check("fast gap", g[i], FGAP[i]);
    for (int i = 0; i < 11; i++) check("fast opcode", o[i], OPS[i]);
  endtask : test_fast

  // Legacy mode: twelve clocks per machine cycle, same timing inside and outside.
  task automatic test_legacy();
    int g[10];
    logic [7:0] o[11];
    run_prog(1'b1, g, o);
    check("legacy mode flag", fast_mode_out, 0);
    for (int i = 0; i < 10; i++) check("legacy gap", g[i], LGAP[i]);
    for (int i = 0; i < 11; i++) check("legacy opcode", o[i], OPS[i]);
  endtask : test_legacy

  // Clock enable low: fetch address and machine state must stand still.
  task automatic test_freeze();
    logic [15:0] a;
    logic [2:0]  m;
    en_in = 1'b0;
    @(negedge clk_in);
    a = code_addr_out;
    m = mstate_out;
    repeat (5) @(negedge clk_in);
    check("frozen address", code_addr_out, a);
    check("frozen state", mstate_out, m);
    en_in = 1'b1;
  endtask : test_freeze

  // Program: a short internal run, then a loop in external code; traps sit after each branch.
  initial begin
    err_count = 0;
    total_checks = 0;
    resetn_in = 1'b0;
    en_in = 1'b1;
    compat_fuse_in = 1'b0;
    taken_in = 1'b1;
    target_in = 16'h8000;
    for (int i = 0; i < 65536; i++) u_mem.rom[i] = 8'h5a;
    u_mem.rom[16'h0000] = 8'h01;
    u_mem.rom[16'h0001] = 8'h22;
    u_mem.rom[16'h0003] = 8'h43;
    u_mem.rom[16'h0006] = 8'h52;
    u_mem.rom[16'h0008] = 8'h22;
    u_mem.rom[16'h8000] = 8'h01;
    u_mem.rom[16'h8001] = 8'h22;
    u_mem.rom[16'h8003] = 8'h52;
    u_mem.rom[16'h8005] = 8'h43;
    test_fast();
    test_legacy();
    test_freeze();
    final_report();
  end

  // Both runs need well under a thousand cycles; this cuts a hang short.
  initial begin
    repeat (6000) @(posedge clk_in);
    err_count++;
    final_report();
  end
endmodule : cft_seq_test
`default_nettype wire
